// >>> hdl/fpeb_classify.sv
// Decides whether the operation in the first execute stage is potentially exceptional.
// Assumes all inputs are on the core clock and stable through the cycle.
`timescale 1ns/100ps
module fpeb_classify
  import fpeb_pkg::*;
(
  fpeb_e1_if.cls e1
);

  // ==========================================================================
  // Classification
  logic arith;

  // Copies, absolute value and negate are in the move class and never reach here.
  assign arith            = e1.valid && (e1.op_class == FPEB_ARITH);
  assign e1.set_invalid   = arith && e1.snan_in;
  assign e1.set_underflow = arith && (e1.underflow || (e1.fast_mode && e1.flushed_zero));
  // Any potential case bounces, not just enabled ones, which costs rare spurious traps.
  assign e1.detect        = arith && (e1.potential || (e1.set_invalid && e1.inv_en)
                            || (e1.set_underflow && e1.uf_en));

endmodule // fpeb_classify

// >>> hdl/fpeb_defines.svh
// Register offsets, field positions, reset values and bus widths of the exception bounce block.
// Assumes inclusion by bare name from design files only.
`ifndef FPEB_DEFINES_SVH
`define FPEB_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define FPEB_ADDR_W       8
`define FPEB_OFF_ECR      8'h00
`define FPEB_OFF_EIR      8'h04
`define FPEB_OFF_SIR      8'h08
`define FPEB_OFF_SCR      8'h0C
`define FPEB_OFF_IST      8'h10
`define FPEB_OFF_IMSK     8'h14

// ==========================================================================
// Exception control register fields
`define FPEB_ECR_PEND     31
`define FPEB_ECR_V2       28
`define FPEB_ECR_ITER_LSB 8
`define FPEB_ITER_W       3

// ==========================================================================
// Status control register fields
`define FPEB_SCR_IOC      0
`define FPEB_SCR_UFC      3
`define FPEB_SCR_IOE      8
`define FPEB_SCR_UFE      11
`define FPEB_SCR_FAST     24
`define FPEB_SCR_RST      32'h0000_0000

// ==========================================================================
// Interrupt status bits
`define FPEB_IRQ_W        3
`define FPEB_IRQ_ENTER    0
`define FPEB_IRQ_BOUNCE   1
`define FPEB_IRQ_UNDEF    2
`define FPEB_IMSK_RST     3'h0

`endif

// >>> hdl/fpeb_e1_if.sv
// First execute stage view shared between the top and its classifier.
// Assumes the package is compiled first.
`timescale 1ns/100ps
interface fpeb_e1_if;
  import fpeb_pkg::*;
  logic          valid;
  fpeb_opclass_t op_class;
  logic          potential;
  logic          snan_in;
  logic          underflow;
  logic          flushed_zero;
  logic          fast_mode;
  logic          inv_en;
  logic          uf_en;
  logic          detect;
  logic          set_invalid;
  logic          set_underflow;

  modport src (output valid, op_class, potential, snan_in, underflow, flushed_zero,
               fast_mode, inv_en, uf_en, input detect, set_invalid, set_underflow);
  modport cls (input valid, op_class, potential, snan_in, underflow, flushed_zero,
               fast_mode, inv_en, uf_en, output detect, set_invalid, set_underflow);
endinterface

// >>> hdl/fpeb_exception_bounce.sv
// Imprecise exception and bounce logic of the floating-point coprocessor, with APB registers.
// Assumes the core decode and first execute stage signals arrive on pclk.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "fpeb_defines.svh"

module fpeb_exception_bounce
  import fpeb_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`FPEB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    dec_valid,
  input  wire logic [31:0]             dec_instr,
  input  wire logic                    dec_undef,
  input  wire logic                    dec_exempt,
  output logic                         dec_accept,
  output logic                         dec_bounce,
  input  wire logic                    e1_valid,
  input  wire logic [31:0]             e1_instr,
  input  wire fpeb_opclass_t           e1_class,
  input  wire logic                    e1_vector,
  input  wire logic [`FPEB_ITER_W-1:0] e1_iter,
  input  wire logic                    e1_potential,
  input  wire logic                    e1_snan,
  input  wire logic                    e1_underflow,
  input  wire logic                    e1_flushed_zero,
  output logic                         vec_cancel,
  output logic                         irq
);

  // ==========================================================================
  // Declarations
  fpeb_state_t             state_reg;
  logic                    v2_reg;
  logic [`FPEB_ITER_W-1:0] iter_reg;
  logic [31:0]             eir_reg;
  logic [31:0]             sir_reg;
  logic [31:0]             scr_reg;
  logic                    slot_valid_reg;
  logic [31:0]             slot_instr_reg;
  logic                    dec_accept_reg;
  logic                    dec_bounce_reg;
  logic                    vec_cancel_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic [31:0]             prdata_reg;
  logic [`FPEB_IRQ_W-1:0]  ist;
  logic [`FPEB_IRQ_W-1:0]  imsk;
  logic                    irq_reg;

  logic                    pending;
  logic                    enter;
  logic                    bounce_now;
  logic                    accept_now;
  logic                    wr_en;
  logic                    mapped;
  logic                    ecr_wr;
  logic                    scr_wr;
  logic [31:0]             ecr_val;
  logic [31:0]             rd_val;
  logic [`FPEB_IRQ_W-1:0]  irq_events;

  fpeb_e1_if e1 ();

  // ==========================================================================
  // Classifier
  assign e1.valid        = e1_valid;
  assign e1.op_class     = e1_class;
  assign e1.potential    = e1_potential;
  assign e1.snan_in      = e1_snan;
  assign e1.underflow    = e1_underflow;
  assign e1.flushed_zero = e1_flushed_zero;
  assign e1.fast_mode    = scr_reg[`FPEB_SCR_FAST];
  assign e1.inv_en       = scr_reg[`FPEB_SCR_IOE];
  assign e1.uf_en        = scr_reg[`FPEB_SCR_UFE];

  fpeb_classify u_classify (
    .e1 (e1.cls)
  );

  // ==========================================================================
  // Bounce decision
  assign pending = (state_reg == FPEB_EXCEPT);
  // Only the first detection is taken; later ones wait for software.
  assign enter   = e1.detect && !pending;

  // A trigger sitting in decode during the detect cycle is refused at once.
  assign bounce_now = dec_valid && (dec_undef
                      || (!dec_exempt && (pending || e1.detect)));
  assign accept_now = dec_valid && !bounce_now;

  // ==========================================================================
  // Bus decode
  // A write lands only at the access edge, where pready is already high.
  assign wr_en  = psel && penable && pready_reg && pwrite;
  assign mapped = (paddr == `FPEB_OFF_ECR) || (paddr == `FPEB_OFF_EIR) ||
                  (paddr == `FPEB_OFF_SIR) || (paddr == `FPEB_OFF_SCR) ||
                  (paddr == `FPEB_OFF_IST) || (paddr == `FPEB_OFF_IMSK);
  assign ecr_wr = wr_en && (paddr == `FPEB_OFF_ECR);
  assign scr_wr = wr_en && (paddr == `FPEB_OFF_SCR);

  always_comb begin
    ecr_val                                                  = 32'h0000_0000;
    ecr_val[`FPEB_ECR_PEND]                                  = pending;
    ecr_val[`FPEB_ECR_V2]                                    = v2_reg;
    ecr_val[`FPEB_ECR_ITER_LSB +: `FPEB_ITER_W]              = iter_reg;
  end

  always_comb begin
    case (paddr)
      `FPEB_OFF_ECR:  rd_val = ecr_val;
      `FPEB_OFF_EIR:  rd_val = eir_reg;
      `FPEB_OFF_SIR:  rd_val = sir_reg;
      `FPEB_OFF_SCR:  rd_val = scr_reg;
      `FPEB_OFF_IST:  rd_val = {{(32-`FPEB_IRQ_W){1'b0}}, ist};
      `FPEB_OFF_IMSK: rd_val = {{(32-`FPEB_IRQ_W){1'b0}}, imsk};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Exceptional state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FPEB_NORMAL;
    end else begin
      case (state_reg)
        FPEB_NORMAL: begin
          if (enter) begin
            state_reg <= FPEB_EXCEPT;
          end
        end
        FPEB_EXCEPT: begin
          // Software must clear this before touching the unit, or it traps forever.
          if (ecr_wr) begin
            state_reg <= FPEB_NORMAL;
          end
        end
        default: begin
          state_reg <= FPEB_NORMAL;
        end
      endcase
    end
  end

  // The iteration field is kept after a clear, so software can still read it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eir_reg  <= 32'h0000_0000;
      iter_reg <= '0;
    end else if (enter) begin
      eir_reg  <= e1_instr;
      iter_reg <= e1_iter;
    end
  end

  // ==========================================================================
  // Pre-trigger slot
  // The slot remembers the last accepted non-exempt instruction since the newest first iteration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_valid_reg <= 1'b0;
      slot_instr_reg <= 32'h0000_0000;
    end else if (accept_now && !dec_exempt) begin
      slot_valid_reg <= 1'b1;
      slot_instr_reg <= dec_instr;
    end else if (e1_valid && !pending && e1_iter == '0) begin
      slot_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v2_reg  <= 1'b0;
      sir_reg <= 32'h0000_0000;
    end else if (enter) begin
      v2_reg  <= slot_valid_reg;
      sir_reg <= slot_instr_reg;
    end else if (ecr_wr) begin
      v2_reg  <= 1'b0;
    end
  end

  // Halting the vector here leaves the remaining iterations for software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_cancel_reg <= 1'b0;
    end else if (enter) begin
      vec_cancel_reg <= e1_vector;
    end else if (ecr_wr) begin
      vec_cancel_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Handshake answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_accept_reg <= 1'b0;
      dec_bounce_reg <= 1'b0;
    end else begin
      dec_accept_reg <= accept_now;
      dec_bounce_reg <= bounce_now;
    end
  end

  // ==========================================================================
  // Status control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_reg <= `FPEB_SCR_RST;
    end else begin
      if (scr_wr) begin
        scr_reg <= pwdata;
      end
      if (e1.set_invalid) begin
        scr_reg[`FPEB_SCR_IOC] <= 1'b1;
      end
      if (e1.set_underflow) begin
        scr_reg[`FPEB_SCR_UFC] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // APB answer
  // Zero wait states: the answer is latched at the setup edge, so reads show that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !mapped;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupts
  // Undefined offers raise their own event, so software can tell them from bounces.
  always_comb begin
    irq_events                   = '0;
    irq_events[`FPEB_IRQ_ENTER]  = enter;
    irq_events[`FPEB_IRQ_BOUNCE] = bounce_now;
    irq_events[`FPEB_IRQ_UNDEF]  = dec_valid && dec_undef;
  end

  fpeb_irq #(
    .W (`FPEB_IRQ_W)
  ) u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .events     (irq_events),
    .clr_wr     (wr_en && (paddr == `FPEB_OFF_IST)),
    .mask_wr    (wr_en && (paddr == `FPEB_OFF_IMSK)),
    .wdata      (pwdata[`FPEB_IRQ_W-1:0]),
    .status_reg (ist),
    .mask_reg   (imsk),
    .irq_reg    (irq_reg)
  );

  // ==========================================================================
  // Outputs
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign dec_accept = dec_accept_reg;
  assign dec_bounce = dec_bounce_reg;
  assign vec_cancel = vec_cancel_reg;
  assign irq        = irq_reg;

endmodule // fpeb_exception_bounce

// >>> hdl/fpeb_irq.sv
// Sticky event status with mask and one level interrupt.
// Assumes event pulses and write strobes on the same clock.
`timescale 1ns/100ps
module fpeb_irq #(
  parameter int W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] events,
  input  wire logic         clr_wr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status_reg,
  output logic      [W-1:0] mask_reg,
  output logic              irq_reg
);

  // ==========================================================================
  // Status, mask and output
  logic [W-1:0] status_next;

  // A new event outweighs a write-one-to-clear in the same cycle.
  assign status_next = (status_reg & ~(clr_wr ? wdata : '0)) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & (mask_wr ? wdata : mask_reg));
    end
  end

endmodule // fpeb_irq

// >>> hdl/fpeb_pkg.sv
// Types shared by the exception bounce block.
// Assumes nothing of its surroundings.
package fpeb_pkg;

  // ==========================================================================
  // Types
  typedef enum logic {
    FPEB_NORMAL = 1'b0,
    FPEB_EXCEPT = 1'b1
  } fpeb_state_t;

  typedef enum logic [1:0] {
    FPEB_ARITH = 2'b00,
    FPEB_MOVE  = 2'b01,
    FPEB_XFER  = 2'b10,
    FPEB_OTHER = 2'b11
  } fpeb_opclass_t;

endpackage

// >>> tb/fpeb_host_model.sv
// Host core side of the decode handshake: presents offers from the bench.
// Assumes requests change by non-blocking assignment just after pclk rises.
`timescale 1ns/100ps
module fpeb_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic [31:0] req_instr,
  input  wire logic        req_undef,
  input  wire logic        req_exempt,
  output logic             dec_valid,
  output logic [31:0]      dec_instr,
  output logic             dec_undef,
  output logic             dec_exempt
);
  logic [31:0] junk_reg;
  // An idle decode word keeps changing, so a stale word can never pass for a fresh one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_reg <= 32'hA5A5_5A5A;
    end else begin
      junk_reg <= ~junk_reg;
    end
  end
  assign dec_valid  = req;
  assign dec_instr  = req ? req_instr : junk_reg;
  assign dec_undef  = req & req_undef;
  assign dec_exempt = req & req_exempt;
endmodule // fpeb_host_model

// >>> tb/fpeb_monitor.sv
// Checker of the decode handshake and exceptional state, bound to the top.
// Assumes pclk and active low presetn of the top module.
`timescale 1ns/100ps
module fpeb_monitor
  import fpeb_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic          dec_valid,
  input wire logic          dec_undef,
  input wire logic          dec_exempt,
  input wire logic          dec_accept,
  input wire logic          dec_bounce,
  input wire logic          e1_valid,
  input wire fpeb_opclass_t e1_class,
  input wire logic          e1_vector,
  input wire logic          e1_potential,
  input wire logic          vec_cancel
);
  // ==========================================================================
  // Helper state
  logic ecr_wr;
  logic det;
  logic pend_q;
  logic last_undef;
  assign ecr_wr = psel && penable && pready && pwrite && (paddr == 8'h00);
  assign det = e1_valid && (e1_class == FPEB_ARITH) && e1_potential;
  // Pending is only known from causes seen at the ports, so it may lag the design.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      last_undef <= 1'b0;
    end else begin
      pend_q <= ecr_wr ? 1'b0 : (pend_q | det | (dec_bounce & ~last_undef));
      last_undef <= dec_valid & dec_undef;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_one_a: assert property (dec_valid |=> dec_accept != dec_bounce)
    else $error("offer not answered by exactly one of accept and bounce");
  no_stray_a: assert property (!dec_valid |=> !(dec_accept || dec_bounce))
    else $error("answer without an offer");
  undef_bounce_a: assert property (dec_valid && dec_undef |=> dec_bounce)
    else $error("undefined offer accepted");
  same_cycle_a: assert property (det && dec_valid && !dec_exempt |=> dec_bounce)
    else $error("offer in decode at detection not refused");
  pend_bounce_a: assert property (pend_q && !ecr_wr && dec_valid && !dec_exempt |=> dec_bounce)
    else $error("offer accepted while exceptional");
  nonarith_ok_a: assert property (e1_valid && e1_class != FPEB_ARITH && !pend_q && !ecr_wr
    && dec_valid && !dec_undef && !dec_exempt |=> dec_accept)
    else $error("non arithmetic operation caused a refusal");
  exempt_ok_a: assert property (dec_valid && dec_exempt && !dec_undef |=> dec_accept)
    else $error("exempt offer refused");
  vec_enter_a: assert property (det && e1_vector && !pend_q |=> vec_cancel)
    else $error("vector detection did not cancel later iterations");
  vec_hold_a: assert property (vec_cancel && !ecr_wr |=> vec_cancel)
    else $error("iteration cancel dropped without a control write");
  vec_clear_a: assert property (ecr_wr && !e1_valid |=> !vec_cancel)
    else $error("control write left iteration cancel set");
endmodule // fpeb_monitor

bind fpeb_exception_bounce fpeb_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .dec_valid(dec_valid),
  .dec_undef(dec_undef), .dec_exempt(dec_exempt), .dec_accept(dec_accept), .dec_bounce(dec_bounce),
  .e1_valid(e1_valid), .e1_class(e1_class), .e1_vector(e1_vector), .e1_potential(e1_potential),
  .vec_cancel(vec_cancel));

// >>> tb/tb_top.sv
// Self-checking bench of the exception bounce block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/100ps
module tb_top;
  import fpeb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, dec_instr, e1_instr = 0, req_instr = 0, x, y;
  logic pready, pslverr, dec_valid, dec_undef, dec_exempt, dec_accept, dec_bounce, vec_cancel, irq;
  logic req = 0, req_undef = 0, req_exempt = 0, e1_valid = 0, e1_vector = 0, e1_potential = 0;
  logic e1_snan = 0, e1_underflow = 0, e1_flushed_zero = 0, b;
  logic [2:0] e1_iter = 0;
  logic [33:0] e;
  fpeb_opclass_t e1_class = FPEB_ARITH;
  int seed = 35307, failures = 0, num_checks = 0, i;
  logic q_d[$];
  logic [33:0] q_a[$];
  always #25 pclk = ~pclk;
  fpeb_exception_bounce u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dec_valid(dec_valid), .dec_instr(dec_instr), .dec_undef(dec_undef), .dec_exempt(dec_exempt),
    .dec_accept(dec_accept), .dec_bounce(dec_bounce), .e1_valid(e1_valid), .e1_instr(e1_instr),
    .e1_class(e1_class), .e1_vector(e1_vector), .e1_iter(e1_iter), .e1_potential(e1_potential),
    .e1_snan(e1_snan), .e1_underflow(e1_underflow), .e1_flushed_zero(e1_flushed_zero),
    .vec_cancel(vec_cancel), .irq(irq));
  fpeb_host_model u_host (.pclk(pclk), .presetn(presetn), .req(req), .req_instr(req_instr),
    .req_undef(req_undef), .req_exempt(req_exempt), .dec_valid(dec_valid), .dec_instr(dec_instr),
    .dec_undef(dec_undef), .dec_exempt(dec_exempt));
  // ==========================================================================
  // Tasks
  task finish_test;
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] ac);
    num_checks++;
    if (ac !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, ac);
      failures++;
    end
  endtask
  // One cycle of first execute stage and decode offer; bb is the expected refusal.
  task cyc(input fpeb_opclass_t c, input logic ev, pot, vec, input logic [2:0] it, input logic [31:0] ei,
           input logic [2:0] fl, input logic dv, un, ex, input logic [31:0] di, input logic bb);
    if (dv) q_d.push_back(bb);
    e1_class <= c;
    e1_valid <= ev;
    e1_potential <= pot;
    e1_vector <= vec;
    e1_iter <= it;
    e1_instr <= ei;
    {e1_snan, e1_underflow, e1_flushed_zero} <= fl;
    req <= dv;
    req_undef <= un;
    req_exempt <= ex;
    req_instr <= di;
    @(posedge pclk);
  endtask
  task idle;
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
    int n;
    q_a.push_back({w, ex});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready timeout", 1, 0);
      finish_test();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // ==========================================================================
  // Result watcher
  always @(negedge pclk) begin
    if (dec_accept === 1'b1 || dec_bounce === 1'b1) begin
      if (q_d.size() == 0) chk("unexpected answer", 0, 1);
      else begin
        b = q_d.pop_front();
        chk("dec_bounce", {31'h0, b}, {31'h0, dec_bounce});
      end
    end
    if (pready === 1'b1) begin
      if (q_a.size() == 0) chk("unexpected pready", 0, 1);
      else begin
        e = q_a.pop_front();
        chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        if (!e[33]) chk("prdata", e[31:0], prdata);
      end
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 5; i++) apb(0, 8'(i * 4 + (i > 0 ? 8 : 0)), 0, {i == 4, 32'h0});
    apb(1, 8'h0C, 32'h0000_0900, 0);
    for (i = 1; i < 4; i++) cyc(fpeb_opclass_t'(i), 1, 1, 0, 0, $random(seed), 3'b111, 1, 0, 0, 0, 0);
    cyc(FPEB_ARITH, 1, 0, 0, 0, 0, 3'b001, 1, 0, 0, 0, 0);
    idle;
    apb(0, 8'h0C, 0, {1'b0, 32'h0000_0900});
    apb(0, 8'h00, 0, 0);
    x = $random(seed);
    y = $random(seed);
    cyc(FPEB_ARITH, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 1, 0, 0, x, 0);
    cyc(FPEB_ARITH, 1, 1, 1, 3'd1, y, 0, 0, 0, 0, 0, 0);
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0);
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1);
    cyc(FPEB_ARITH, 1, 1, 0, 0, ~y, 0, 1, 0, 0, 0, 1);
    idle;
    chk("vec_cancel", 1, {31'h0, vec_cancel});
    apb(0, 8'h00, 0, {1'b0, 32'h9000_0100});
    apb(0, 8'h04, 0, {1'b0, y});
    apb(0, 8'h08, 0, {1'b0, x});
    apb(1, 8'h00, 0, 0);
    chk("vec_cancel", 0, {31'h0, vec_cancel});
    apb(0, 8'h00, 0, {1'b0, 32'h0000_0100});
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 1, 0, 0, x, 0);
    cyc(FPEB_ARITH, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    cyc(FPEB_ARITH, 1, 1, 0, 0, x, 0, 1, 0, 0, y, 1);
    idle;
    apb(0, 8'h00, 0, {1'b0, 32'h8000_0000});
    apb(0, 8'h04, 0, {1'b0, x});
    apb(1, 8'h00, 0, 0);
    cyc(FPEB_ARITH, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 1);
    idle;
    apb(0, 8'h00, 0, 0);
    apb(1, 8'h0C, 32'h0100_0900, 0);
    cyc(FPEB_ARITH, 1, 0, 0, 0, 0, 3'b001, 1, 0, 0, 0, 1);
    idle;
    apb(0, 8'h0C, 0, {1'b0, 32'h0100_0908});
    apb(1, 8'h00, 0, 0);
    apb(0, 8'h10, 0, {1'b0, 32'h7});
    chk("irq", 0, {31'h0, irq});
    apb(1, 8'h14, 32'h4, 0);
    repeat (3) @(posedge pclk);
    chk("irq", 1, {31'h0, irq});
    apb(1, 8'h10, 32'h4, 0);
    repeat (3) @(posedge pclk);
    chk("irq", 0, {31'h0, irq});
    apb(0, 8'h10, 0, {1'b0, 32'h3});
    apb(0, 8'h14, 0, {1'b0, 32'h4});
    apb(1, 8'h08, 32'h5, 0);
    apb(0, 8'h08, 0, {1'b0, x});
    chk("answers left", 0, 32'(q_d.size()));
    finish_test();
  end
endmodule // tb_top
